// ---- mac_side.sv ----
// Receive and transmit qualification paths issuing end-of-frame reports
`timescale 1ns/1ps
`default_nettype none
module mac_side
(
   input  wire logic                         aclk,
   output var stat_counters_pkg::rx_report_s rx_report,
   output var stat_counters_pkg::tx_report_s tx_report,
   output logic                              rx_fifo_space
);
   initial
   begin
      rx_report = '0;
      tx_report = '0;
      rx_fifo_space = 1'b0;
   end
   // One-cycle report; room level is held so idle cycles see it too
   task automatic rx(input logic [14:0] len, input logic [8:0] f, input logic sp);
      @(posedge aclk);
      rx_report <= {1'b1, len, f};
      rx_fifo_space <= sp;
      @(posedge aclk);
      rx_report <= '0;
   endtask : rx
   task automatic tx(input logic [14:0] len, input logic [1:0] f);
      @(posedge aclk);
      tx_report <= {1'b1, len, f};
      @(posedge aclk);
      tx_report <= '0;
   endtask : tx
endmodule : mac_side
`default_nettype wire

// ---- stat_counters.sv ----
// Statistics counter bank with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "stat_counters_params.svh"

// Summary of operation
// - Count good filtered legal rx, skip flow/missed
// - Legal rx length follows jumbo allow
// - Rx counters move only with rx enabled
// - Tx packet and octet counters need tx
// - Count good broadcasts unless filter disabled
// - Count good filtered multicasts, skip flow/missed
// - Good tx: error-free, 64+ bytes, not flow
// - 64-bit good rx octets, filtered, no flow
// - 64-bit good tx octets, 64+, no flow
// - Reading upper half clears octet counter
// - Octet counters saturate at all ones
// - Count frames with no host buffer
// - Frame still enters FIFO when space
// - Fragment: filtered, under 64, bad CRC
// - Oversize: filtered, over max, good CRC
// - Jabber: filtered, over max, bad CRC
// - Max is 1522, or 16384 when jumbo
// - Length spans destination through CRC
// - Event counters 32 bits, octet counters 64, all zero at reset
module stat_counters
(
   // Clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // Enables from the control registers
   input  wire logic                          rx_enable,
   input  wire logic                          tx_enable,
   input  wire logic                          jumbo_frame_allow,
   // Frame reports from the MAC paths and FIFO room
   input  wire stat_counters_pkg::rx_report_s rx_report,
   input  wire stat_counters_pkg::tx_report_s tx_report,
   output logic                               rx_fifo_accept,
   input  wire logic                          rx_fifo_space,
   // AXI4-Lite write channels
   input  wire logic [15:0]                   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [15:0]                   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready
);

   // Slots of the 32-bit event counters; the octet pairs live apart
   localparam int NCNT           = 9;
   localparam int SLOT_GOOD_RX   = 0; // Good received packets
   localparam int SLOT_BCAST_RX  = 1; // Good broadcasts
   localparam int SLOT_MCAST_RX  = 2; // Good multicasts
   localparam int SLOT_GOOD_TX   = 3; // Good transmitted packets
   localparam int SLOT_NO_BUF    = 4; // Frames seen with no host buffer
   localparam int SLOT_UNDERSIZE = 5; // Short frames, good CRC
   localparam int SLOT_FRAGMENT  = 6; // Short frames, bad CRC
   localparam int SLOT_OVERSIZE  = 7; // Long frames, good CRC
   localparam int SLOT_JABBER    = 8; // Long frames, bad CRC

   // Counter storage
   logic [31:0]     cnt_ff [NCNT];
   logic [NCNT-1:0] inc;
   logic [63:0]     rx_oct_ff;
   logic [63:0]     tx_oct_ff;

   // Frame qualification terms
   logic [14:0]     max_len;
   logic            rx_ok;
   logic            rx_legal;
   logic            rx_short;
   logic            rx_long;
   logic            tx_good;
   logic            rx_oct_inc;
   logic            tx_oct_inc;

   // Write channel state
   logic            aw_held_ff;
   logic            w_held_ff;
   logic [15:0]     awaddr_ff;
   logic            aw_take;
   logic            w_take;
   logic            wr_complete;

   // Read path
   logic [31:0]     rdata;
   logic            rmapped;
   logic            rd_take;
   logic            rd_rx_high;
   logic            rd_tx_high;

   // Saturating 64-bit add; a wrap would make the total look tiny
   function automatic logic [63:0] sat_add(input logic [63:0] a, input logic [14:0] b);
      logic [64:0] s;
      // One spare bit catches the carry out of the top
      s = {1'b0, a} + {50'h0, b};
      // Stick at all ones once the carry appears
      sat_add = s[64] ? `OCTET_MAX : s[63:0];
   endfunction : sat_add

   // Next octet total: a read of the upper half clears, else a good frame adds
   function automatic logic [63:0] oct_next(input logic [63:0] cur,
                                             input logic        clr,
                                             input logic        add,
                                             input logic [14:0] len);
      if (clr)
         oct_next = `OCTET_RESET;
      else if (add)
         oct_next = sat_add(cur, len);
      else
         oct_next = cur;
   endfunction : oct_next

   // A receive report that reception is allowed to act on
   function automatic logic rx_seen(input stat_counters_pkg::rx_report_s rep,
                                    input logic                          en);
      rx_seen = rep.done && en;
   endfunction : rx_seen

   // Length-error counters share this gate; other_err does not block them
   function automatic logic rx_len_gate(input stat_counters_pkg::rx_report_s rep,
                                        input logic                          en);
      rx_len_gate = rx_seen(rep, en) && rep.addr_pass;
   endfunction : rx_len_gate

   // Read address match, used by both clear-on-read strobes
   function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] ofs);
      addr_hit = (addr == ofs);
   endfunction : addr_hit

   // Length limit follows the jumbo setting
   assign max_len  = jumbo_frame_allow ? `MAX_FRAME_JUMBO_BYTES : `MAX_FRAME_STD_BYTES;

   // Length classes; the length runs from destination address through CRC
   assign rx_short = rx_report.length < `MIN_FRAME_BYTES;
   assign rx_long  = rx_report.length > max_len;

   // Legal length sits between the minimum and the current maximum
   assign rx_legal = !rx_short && !rx_long;

   // A good rx frame: reported, reception on, no CRC or other error
   assign rx_ok    = rx_seen(rx_report, rx_enable) && rx_report.crc_ok
                     && !rx_report.other_err;

   // A good tx frame: transmission on, no error, not pause, at least minimum size
   assign tx_good  = tx_report.done && tx_enable && tx_report.ok && !tx_report.flow_ctrl
                     && (tx_report.length >= `MIN_FRAME_BYTES);

   // Increment requests for the 32-bit counters
   always_comb
   begin
      inc = '0;
      // Good packets of legal length that passed filtering
      inc[SLOT_GOOD_RX]   = rx_ok && rx_legal && rx_report.addr_pass
                            && !rx_report.flow_ctrl && !rx_report.missed;
      // Broadcasts need only the broadcast accept setting, not the filter result
      inc[SLOT_BCAST_RX]  = rx_ok && rx_report.broadcast && rx_report.bcast_filter_en;
      // Multicasts that passed filtering
      inc[SLOT_MCAST_RX]  = rx_ok && rx_report.multicast && rx_report.addr_pass
                            && !rx_report.flow_ctrl && !rx_report.missed;
      // Transmit side uses the shared good-frame term
      inc[SLOT_GOOD_TX]   = tx_good;
      // No host buffer: counted even for bad frames, never for pause frames
      inc[SLOT_NO_BUF]    = rx_seen(rx_report, rx_enable) && rx_report.no_host_buf
                            && !rx_report.flow_ctrl;
      // Length errors, split by CRC result
      inc[SLOT_UNDERSIZE] = rx_len_gate(rx_report, rx_enable) && rx_short
                            && rx_report.crc_ok;
      inc[SLOT_FRAGMENT]  = rx_len_gate(rx_report, rx_enable) && rx_short
                            && !rx_report.crc_ok;
      inc[SLOT_OVERSIZE]  = rx_len_gate(rx_report, rx_enable) && rx_long
                            && rx_report.crc_ok;
      inc[SLOT_JABBER]    = rx_len_gate(rx_report, rx_enable) && rx_long
                            && !rx_report.crc_ok;
   end

   // 32-bit event counters, wrapping like the packet counters they mirror
   generate
      for (genvar i = 0; i < NCNT; i++)
      begin : g_cnt
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               cnt_ff[i] <= `COUNT_RESET;
            else if (inc[i])
               cnt_ff[i] <= cnt_ff[i] + 32'h1;
         end
      end
   endgenerate

   // FIFO admission does not depend on host buffers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_fifo_accept <= 1'b0;
      else
         rx_fifo_accept <= rx_report.done && rx_fifo_space;
   end

   // Rx octets take any length; missed frames still add their bytes
   assign rx_oct_inc = rx_ok && rx_report.addr_pass && !rx_report.flow_ctrl;

   // Tx octets follow the good-packet decision exactly
   assign tx_oct_inc = tx_good;

   // Good rx octets; a clear on read wins over a same-cycle add
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_oct_ff <= `OCTET_RESET;
      else
         rx_oct_ff <= oct_next(rx_oct_ff, rd_rx_high, rx_oct_inc, rx_report.length);
   end

   // Good tx octets; the add lost to a clear is not replayed
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tx_oct_ff <= `OCTET_RESET;
      else
         tx_oct_ff <= oct_next(tx_oct_ff, rd_tx_high, tx_oct_inc, tx_report.length);
   end

   // Read decode
   always_comb
   begin
      rdata   = 32'h0;
      rmapped = 1'b1;
      case (s_axi_araddr)
         // Packet counters
         `OFS_GOOD_RX_PACKET_COUNT:      rdata = cnt_ff[SLOT_GOOD_RX];
         `OFS_BROADCAST_RX_PACKET_COUNT: rdata = cnt_ff[SLOT_BCAST_RX];
         `OFS_MULTICAST_RX_PACKET_COUNT: rdata = cnt_ff[SLOT_MCAST_RX];
         `OFS_GOOD_TX_PACKET_COUNT:      rdata = cnt_ff[SLOT_GOOD_TX];
         // Octet halves; the high half read also clears
         `OFS_GOOD_RX_OCTETS_LOW:        rdata = rx_oct_ff[31:0];
         `OFS_GOOD_RX_OCTETS_HIGH:       rdata = rx_oct_ff[63:32];
         `OFS_GOOD_TX_OCTETS_LOW:        rdata = tx_oct_ff[31:0];
         `OFS_GOOD_TX_OCTETS_HIGH:       rdata = tx_oct_ff[63:32];
         // Receive no-buffer and length errors
         `OFS_RX_NO_BUFFER_COUNT:        rdata = cnt_ff[SLOT_NO_BUF];
         `OFS_RX_UNDERSIZE_COUNT:        rdata = cnt_ff[SLOT_UNDERSIZE];
         `OFS_RX_FRAGMENT_COUNT:         rdata = cnt_ff[SLOT_FRAGMENT];
         `OFS_RX_OVERSIZE_COUNT:         rdata = cnt_ff[SLOT_OVERSIZE];
         `OFS_RX_JABBER_COUNT:           rdata = cnt_ff[SLOT_JABBER];
         // Anything else is refused and reads as zero
         default:                        rmapped = 1'b0;
      endcase
   end

   // A read is taken when ready is offered and valid is seen
   assign rd_take    = s_axi_arvalid && s_axi_arready;

   // Clear strobes fire once, at the edge that takes the read
   assign rd_rx_high = rd_take && addr_hit(s_axi_araddr, `OFS_GOOD_RX_OCTETS_HIGH);
   assign rd_tx_high = rd_take && addr_hit(s_axi_araddr, `OFS_GOOD_TX_OCTETS_HIGH);

   // Address ready: low from a take until a cycle after the answer is gone
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_arready <= 1'b0;
      else if (rd_take)
         s_axi_arready <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // Answer valid one cycle after the take, held until the master accepts it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_rvalid <= 1'b0;
      else if (rd_take)
         s_axi_rvalid <= 1'b1;
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Answer payload captured at the take, so a later count does not tear it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end
      else if (rd_take)
      begin
         s_axi_rdata <= rdata;
         s_axi_rresp <= rmapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
   end

   // Write channel: all counters are read-only, so writes are answered and dropped
   assign aw_take     = s_axi_awvalid && s_axi_awready;
   assign w_take      = s_axi_wvalid && s_axi_wready;
   assign wr_complete = aw_held_ff && w_held_ff && !s_axi_bvalid;

   // Address ready stays low from a take until the response has gone
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_awready <= 1'b0;
      else
         s_axi_awready <= !aw_held_ff && !aw_take && !s_axi_bvalid;
   end

   // Data ready follows the same pattern, so either may come first
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_wready <= 1'b0;
      else
         s_axi_wready <= !w_held_ff && !w_take && !s_axi_bvalid;
   end

   // Held address; dropped once the response is raised
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         awaddr_ff  <= 16'h0;
      end
      else if (wr_complete)
         aw_held_ff <= 1'b0;
      else if (aw_take)
      begin
         aw_held_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end
   end

   // Held data flag; the data itself is not kept
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         w_held_ff <= 1'b0;
      else if (wr_complete)
         w_held_ff <= 1'b0;
      else if (w_take)
         w_held_ff <= 1'b1;
   end

   // Response once both halves are held; OKAY on the counter page only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_RESP_OKAY;
      end
      else if (wr_complete)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_ff[15:12] == 4'h4) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

endmodule : stat_counters
`default_nettype wire

// ---- stat_counters_monitor.sv ----
// Port-level checker for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
`include "stat_counters_params.svh"
module stat_counters_monitor
(
   input wire logic                          aclk,
   input wire logic                          aresetn,
   input wire stat_counters_pkg::rx_report_s rx_report,
   input wire logic                          rx_fifo_space,
   input wire logic                          rx_fifo_accept,
   input wire logic [15:0]                   s_axi_araddr,
   input wire logic                          s_axi_arvalid,
   input wire logic                          s_axi_arready,
   input wire logic [31:0]                   s_axi_rdata,
   input wire logic [1:0]                    s_axi_rresp,
   input wire logic                          s_axi_rvalid,
   input wire logic                          s_axi_rready,
   input wire logic                          s_axi_awvalid,
   input wire logic                          s_axi_awready,
   input wire logic                          s_axi_wvalid,
   input wire logic                          s_axi_wready,
   input wire logic [1:0]                    s_axi_bresp,
   input wire logic                          s_axi_bvalid,
   input wire logic                          s_axi_bready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // FIFO takes a frame on room alone, host buffers do not matter
   a_fifo_take: assert property (rx_report.done && rx_fifo_space |=> rx_fifo_accept)
      else $error("frame with room not accepted");
   a_fifo_idle: assert property (!(rx_report.done && rx_fifo_space) |=> !rx_fifo_accept)
      else $error("accept without frame and room");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed before taken");
   a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[15:12] != 4'h4
      |=> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_write_done: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
endmodule : stat_counters_monitor
bind stat_counters stat_counters_monitor u_mon (.*);
`default_nettype wire

// ---- stat_counters_params.svh ----
// Register offsets, limits and reset values of the statistics counter bank
`ifndef STAT_COUNTERS_PARAMS_SVH
`define STAT_COUNTERS_PARAMS_SVH

`define OFS_GOOD_RX_PACKET_COUNT      16'h4074
`define OFS_BROADCAST_RX_PACKET_COUNT 16'h4078
`define OFS_MULTICAST_RX_PACKET_COUNT 16'h407c
`define OFS_GOOD_TX_PACKET_COUNT      16'h4080
`define OFS_GOOD_RX_OCTETS_LOW        16'h4088
`define OFS_GOOD_RX_OCTETS_HIGH       16'h408c
`define OFS_GOOD_TX_OCTETS_LOW        16'h4090
`define OFS_GOOD_TX_OCTETS_HIGH       16'h4094
`define OFS_RX_NO_BUFFER_COUNT        16'h40a0
`define OFS_RX_UNDERSIZE_COUNT        16'h40a4
`define OFS_RX_FRAGMENT_COUNT         16'h40a8
`define OFS_RX_OVERSIZE_COUNT         16'h40ac
`define OFS_RX_JABBER_COUNT           16'h40b0
`define MIN_FRAME_BYTES               15'h0040
`define MAX_FRAME_STD_BYTES           15'h05f2
`define MAX_FRAME_JUMBO_BYTES         15'h4000
`define COUNT_RESET                   32'h0000_0000
`define OCTET_RESET                   64'h0000_0000_0000_0000
`define OCTET_MAX                     64'hffff_ffff_ffff_ffff
`define AXI_RESP_OKAY                 2'h0
`define AXI_RESP_SLVERR               2'h2

`endif

// ---- stat_counters_pkg.sv ----
// Types shared by the statistics counter bank
package stat_counters_pkg;

   // Receive frame report, valid for one cycle at end of frame
   typedef struct packed {
      logic        done;
      logic [14:0] length;
      logic        crc_ok;
      logic        other_err;
      logic        addr_pass;
      logic        broadcast;
      logic        multicast;
      logic        bcast_filter_en;
      logic        flow_ctrl;
      logic        missed;
      logic        no_host_buf;
   } rx_report_s;

   // Transmit frame report, valid for one cycle at end of frame
   typedef struct packed {
      logic        done;
      logic [14:0] length;
      logic        ok;
      logic        flow_ctrl;
   } tx_report_s;

endpackage : stat_counters_pkg

// ---- tb_mac_rx_tx_statistics_counters.sv ----
// Self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
`include "stat_counters_params.svh"
`define CHK(a, b) check_count++; if ((a) !== (b)) begin failures++; $display("BAD %0t got %h want %h", $time, a, b); end
module tb_mac_rx_tx_statistics_counters;
   logic aclk = 1'b0, aresetn = 1'b0, rx_enable = 1'b0, tx_enable = 1'b0, jumbo_frame_allow = 1'b0;
   stat_counters_pkg::rx_report_s rx_report;
   stat_counters_pkg::tx_report_s tx_report;
   logic        rx_fifo_space, rx_fifo_accept, awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, wdata = 32'h0;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   int          failures = 0, check_count = 0;
   logic [31:0] exp_cnt [13] = '{default: 32'h0};
   logic [15:0] ofs [13] = '{16'h4074, 16'h4078, 16'h407c, 16'h4080, 16'h4088, 16'h408c,
      16'h4090, 16'h4094, 16'h40a0, 16'h40a4, 16'h40a8, 16'h40ac, 16'h40b0};
   always #5 aclk = ~aclk;
   mac_side u_mac (.aclk(aclk), .rx_report(rx_report), .tx_report(tx_report),
      .rx_fifo_space(rx_fifo_space));
   stat_counters u_dut
   (
      .aclk(aclk), .aresetn(aresetn), .rx_enable(rx_enable), .tx_enable(tx_enable),
      .jumbo_frame_allow(jumbo_frame_allow), .rx_report(rx_report), .tx_report(tx_report),
      .rx_fifo_accept(rx_fifo_accept), .rx_fifo_space(rx_fifo_space),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );
   task automatic tally_and_finish();
      if (failures == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // Read held until taken, answer taken at the edge rvalid is seen
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      while (awvalid || wvalid);
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   // Low half read before high half; high read clears, so zero the model
   task automatic check_all();
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 13; i++)
      begin
         rd(ofs[i], d, r);
         `CHK({r, d}, {`AXI_RESP_OKAY, exp_cnt[i]})
      end
      for (int i = 4; i < 8; i++)
         exp_cnt[i] = 32'h0;
   endtask : check_all
   task automatic t_bus();
      logic [31:0] d;
      logic [1:0]  r;
      wr(16'h4074, 32'h1234_5678, r);
      `CHK(r, `AXI_RESP_OKAY)
      wr(16'h0100, 32'h1, r);
      `CHK(r, `AXI_RESP_SLVERR)
      rd(16'h4084, d, r);
      `CHK({r, d}, {`AXI_RESP_SLVERR, 32'h0})
      rd(16'h0100, d, r);
      `CHK({r, d}, {`AXI_RESP_SLVERR, 32'h0})
   endtask : t_bus
   // Flags: crc, err, addr, bcast, mcast, bcast_en, flow, missed, no_buf
   task automatic t_rx_good();
      u_mac.rx(15'h064, 9'h150, 1'b1);
      u_mac.rx(15'h064, 9'h120, 1'b1);
      u_mac.rx(15'h064, 9'h128, 1'b0);
      u_mac.rx(15'h064, 9'h144, 1'b1);
      u_mac.rx(15'h064, 9'h142, 1'b1);
      u_mac.rx(15'h064, 9'h1c0, 1'b1);
      exp_cnt = '{32'h1, 32'h1, 32'h1, 32'h0, 32'hc8, 32'h0, 32'h0, 32'h0,
         32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      check_all();
   endtask : t_rx_good
   // Length boundaries at both maximum settings
   task automatic t_len();
      u_mac.rx(15'h03f, 9'h140, 1'b1);
      u_mac.rx(15'h03f, 9'h040, 1'b1);
      u_mac.rx(15'h040, 9'h140, 1'b1);
      u_mac.rx(15'h05f2, 9'h140, 1'b1);
      u_mac.rx(15'h05f3, 9'h140, 1'b1);
      u_mac.rx(15'h05f3, 9'h040, 1'b1);
      jumbo_frame_allow <= 1'b1;
      u_mac.rx(15'h05f3, 9'h140, 1'b1);
      u_mac.rx(15'h4000, 9'h140, 1'b1);
      u_mac.rx(15'h4001, 9'h140, 1'b1);
      u_mac.rx(15'h4001, 9'h040, 1'b1);
      jumbo_frame_allow <= 1'b0;
      exp_cnt = '{32'h5, 32'h1, 32'h1, 32'h0, 32'h9258, 32'h0, 32'h0, 32'h0,
         32'h0, 32'h1, 32'h1, 32'h2, 32'h2};
      check_all();
   endtask : t_len
   // Disabled paths stay still; then no-buffer and transmit qualification
   task automatic t_gate();
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      u_mac.rx(15'h064, 9'h151, 1'b0);
      u_mac.tx(15'h040, 2'h2);
      rx_enable <= 1'b1;
      tx_enable <= 1'b1;
      u_mac.rx(15'h064, 9'h001, 1'b1);
      u_mac.rx(15'h064, 9'h005, 1'b0);
      u_mac.tx(15'h040, 2'h2);
      u_mac.tx(15'h03f, 2'h2);
      u_mac.tx(15'h040, 2'h3);
      u_mac.tx(15'h040, 2'h0);
      u_mac.tx(15'h05f2, 2'h2);
      exp_cnt = '{32'h5, 32'h1, 32'h1, 32'h2, 32'h0, 32'h0, 32'h632, 32'h0,
         32'h1, 32'h1, 32'h1, 32'h2, 32'h2};
      check_all();
   endtask : t_gate
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rx_enable <= 1'b1;
      tx_enable <= 1'b1;
      check_all();
      t_bus();
      t_rx_good();
      t_len();
      t_gate();
      tally_and_finish();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      failures++;
      tally_and_finish();
   end
endmodule : tb_mac_rx_tx_statistics_counters
`default_nettype wire
